// ===== shared/accel_irq_pkg.sv
// Register map, field positions and encodings of the interrupt routing block
package accel_irq_pkg;
	// Register offsets on the internal register port
	localparam logic [7:0] ADDR_EVENT_SOURCE   = 8'h0a;
	localparam logic [7:0] ADDR_LATCH_CLEAR    = 8'h17;
	localparam logic [7:0] ADDR_CONTROL_ONE    = 8'h18;
	localparam logic [7:0] ADDR_LATENCY_TIME   = 8'h1d;
	localparam logic [7:0] ADDR_SECOND_WINDOW  = 8'h1e;

	// Reset values
	localparam logic [7:0] RST_EVENT_SOURCE    = 8'h00;
	localparam logic [1:0] RST_LATCH_CLEAR     = 2'h0;
	localparam logic [7:0] RST_CONTROL_ONE     = 8'h00;
	localparam logic [7:0] RST_LATENCY_TIME    = 8'h01;
	localparam logic [7:0] RST_SECOND_WINDOW   = 8'h00;
	localparam logic [7:0] ZERO_BYTE           = 8'h00;

	// Control one fields
	localparam int CTL_SWAP_BIT                = 0;
	localparam int CTL_ASSIGN_LO               = 1;
	localparam int CTL_ASSIGN_HI               = 2;

	// Latch clear fields
	localparam int CLR_FIRST_BIT               = 0;
	localparam int CLR_SECOND_BIT              = 1;

	// Event source fields
	localparam int SRC_FIRST_FLAG              = 0;
	localparam int SRC_SECOND_FLAG             = 1;
	localparam int SRC_PULSE_Z                 = 2;
	localparam int SRC_PULSE_Y                 = 3;
	localparam int SRC_PULSE_X                 = 4;
	localparam int SRC_LEVEL_Z                 = 5;
	localparam int SRC_LEVEL_Y                 = 6;
	localparam int SRC_LEVEL_X                 = 7;

	// Interrupt assignment encodings
	typedef enum logic [1:0] {
		ASSIGN_LEVEL_PULSE = 2'b00,
		ASSIGN_PULSE_LEVEL = 2'b01,
		ASSIGN_SINGLE_DBL  = 2'b10,
		ASSIGN_RESERVED    = 2'b11
	} irq_assign_e;
endpackage

// ===== rtl/accel_irq_routing_latch.sv
// Interrupt assignment, latching, clearing and source reporting of the accelerometer
`timescale 1ns/100ps
`default_nettype none

module accel_irq_routing_latch (
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_rd,
	input  wire logic       i_level_event_x,
	input  wire logic       i_level_event_y,
	input  wire logic       i_level_event_z,
	input  wire logic       i_first_pulse_x,
	input  wire logic       i_first_pulse_y,
	input  wire logic       i_first_pulse_z,
	input  wire logic       i_double_pulse,
	output logic      [7:0] o_reg_rdata,
	output logic            o_first_irq_line,
	output logic            o_second_irq_line,
	output logic            o_detect_restart
);
	import accel_irq_pkg::*;

	logic [7:0]  control_one_config;
	logic [1:0]  latch_reset_reg;
	logic [7:0]  latency_time;
	logic [7:0]  second_pulse_window;
	logic [5:0]  axis_events;
	logic        first_flag;
	logic        second_flag;
	irq_assign_e irq_assign_sel;
	logic        irq_output_swap;
	logic        clear_first_flag;
	logic        clear_second_flag;
	logic        level_any;
	logic        single_any;
	logic        double_only;
	logic        first_event;
	logic        second_event;
	logic        first_clear;
	logic        second_clear;

	// Event selected for a flag under the given assignment
	function automatic logic pick_event(input irq_assign_e sel, input logic second,
			input logic level, input logic single, input logic dbl_only, input logic dbl);
		logic ev;
		ev = 1'b0;
		case (sel)
			ASSIGN_PULSE_LEVEL: ev = second ? level : single;
			ASSIGN_SINGLE_DBL:  ev = (second && dbl_only) ? dbl : single;
			default:            ev = second ? single : level;
		endcase
		return ev;
	endfunction

	// Field decode
	assign irq_assign_sel    = irq_assign_e'(control_one_config[CTL_ASSIGN_HI:CTL_ASSIGN_LO]);
	assign irq_output_swap   = control_one_config[CTL_SWAP_BIT];
	assign clear_first_flag  = latch_reset_reg[CLR_FIRST_BIT];
	assign clear_second_flag = latch_reset_reg[CLR_SECOND_BIT];
	assign level_any   = i_level_event_x | i_level_event_y | i_level_event_z;
	assign single_any  = i_first_pulse_x | i_first_pulse_y | i_first_pulse_z;
	assign double_only = (second_pulse_window != ZERO_BYTE) && (latency_time != ZERO_BYTE);

	// Event routing to the two flags
	assign first_event  = pick_event(irq_assign_sel, 1'b0, level_any, single_any, double_only, i_double_pulse);
	assign second_event = pick_event(irq_assign_sel, 1'b1, level_any, single_any, double_only, i_double_pulse);

	// Clear terms; in single/double mode only the second clear bit acts
	assign first_clear  = (irq_assign_sel == ASSIGN_SINGLE_DBL) ? clear_second_flag : clear_first_flag;
	assign second_clear = clear_second_flag;

	// Writable registers
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			control_one_config  <= RST_CONTROL_ONE;
			latch_reset_reg     <= RST_LATCH_CLEAR;
			latency_time        <= RST_LATENCY_TIME;
			second_pulse_window <= RST_SECOND_WINDOW;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_CONTROL_ONE:   control_one_config <= i_reg_wdata;
				ADDR_LATCH_CLEAR:   latch_reset_reg <= i_reg_wdata[CLR_SECOND_BIT:CLR_FIRST_BIT];
				ADDR_LATENCY_TIME:  latency_time <= i_reg_wdata;
				ADDR_SECOND_WINDOW: second_pulse_window <= i_reg_wdata;
				default:            ; // Source register and unmapped writes ignored
			endcase
		end
	end

	// Interrupt flags; a held clear term keeps its flag clear
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			first_flag  <= 1'b0;
			second_flag <= 1'b0;
		end else begin
			if (first_clear) begin
				first_flag <= 1'b0;
			end else if (first_event) begin
				first_flag <= 1'b1;
			end
			if (second_clear) begin
				second_flag <= 1'b0;
			end else if (second_event) begin
				second_flag <= 1'b1;
			end
		end
	end

	// Per-axis source bits, cleared by any clear term that acts; an ignored clear bit leaves them
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			axis_events <= RST_EVENT_SOURCE[SRC_LEVEL_X:SRC_PULSE_Z];
		end else if (first_clear || second_clear) begin
			axis_events <= RST_EVENT_SOURCE[SRC_LEVEL_X:SRC_PULSE_Z];
		end else begin
			axis_events <= axis_events | {i_level_event_x, i_level_event_y, i_level_event_z,
				i_first_pulse_x, i_first_pulse_y, i_first_pulse_z};
		end
	end

	// Pin routing, straight or crossed
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_first_irq_line  <= 1'b0;
			o_second_irq_line <= 1'b0;
		end else begin
			o_first_irq_line  <= irq_output_swap ? second_flag : first_flag;
			o_second_irq_line <= irq_output_swap ? first_flag : second_flag;
		end
	end

	// Detection restart, high while the second clear bit is set in single/double mode
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_detect_restart <= 1'b0;
		end else begin
			o_detect_restart <= (irq_assign_sel == ASSIGN_SINGLE_DBL) && clear_second_flag;
		end
	end

	// Register read data, one cycle after the read strobe
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata <= ZERO_BYTE;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_EVENT_SOURCE:  o_reg_rdata <= {axis_events, second_flag, first_flag};
				ADDR_LATCH_CLEAR:   o_reg_rdata <= {6'h00, latch_reset_reg};
				ADDR_CONTROL_ONE:   o_reg_rdata <= control_one_config;
				ADDR_LATENCY_TIME:  o_reg_rdata <= latency_time;
				ADDR_SECOND_WINDOW: o_reg_rdata <= second_pulse_window;
				default:            o_reg_rdata <= ZERO_BYTE;
			endcase
		end
	end

	// Checks
	AST_ASSIGN_00: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_LEVEL_PULSE && !first_clear && level_any) |=> first_flag)
		else $error("Level event not latched on first flag");
	AST_ASSIGN_01: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_PULSE_LEVEL && !second_clear && level_any) |=> second_flag)
		else $error("Level event not latched on second flag");
	AST_ASSIGN_10: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && !second_clear && !second_flag && double_only
		&& single_any && !i_double_pulse) |=> !second_flag)
		else $error("Single pulse latched while double only");
	AST_ASSIGN_11: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_RESERVED && !second_clear && single_any) |=> second_flag)
		else $error("Reserved assignment not treated as default");
	AST_STRAIGHT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!irq_output_swap |=> (o_first_irq_line == $past(first_flag)))
		else $error("Straight routing wrong");
	AST_CROSSED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		irq_output_swap |=> (o_second_irq_line == $past(first_flag)) && (o_first_irq_line == $past(second_flag)))
		else $error("Crossed routing wrong");
	AST_MODE10_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && clear_second_flag) |=> !first_flag && !second_flag && o_detect_restart)
		else $error("Second clear did not clear both flags");
	AST_MODE10_FIRST_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && clear_first_flag && !clear_second_flag && first_flag) |=> first_flag)
		else $error("First clear acted in single/double mode");
	AST_CLEAR_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		clear_second_flag [*2] |-> !second_flag)
		else $error("Flag set while clear bit held");
	AST_SOURCE_AXES: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!clear_first_flag && !clear_second_flag && i_level_event_x && i_first_pulse_z)
		|=> axis_events[SRC_LEVEL_X - SRC_PULSE_Z] && axis_events[SRC_PULSE_Z - SRC_PULSE_Z])
		else $error("Axis source bit not set");
	AST_SOURCE_FLAGS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_rd && i_reg_addr == ADDR_EVENT_SOURCE)
		|=> o_reg_rdata[SRC_FIRST_FLAG] == $past(first_flag) && o_reg_rdata[SRC_SECOND_FLAG] == $past(second_flag))
		else $error("Source flag bits wrong");
	AST_SOURCE_RO: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_EVENT_SOURCE) |=> $stable(control_one_config) && $stable(latch_reset_reg))
		else $error("Write to source register changed state");
	AST_PIN_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(first_flag && second_flag) |=> o_first_irq_line && o_second_irq_line)
		else $error("Pin low while event latched");
	AST_WINDOW_SELECT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && second_pulse_window == ZERO_BYTE && !second_clear && single_any)
		|=> second_flag)
		else $error("Zero window did not select single pulse");

	// Register port: writes land, reads return the stored value
	AST_CTRL_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_CONTROL_ONE) |=> control_one_config == $past(i_reg_wdata))
		else $error("Control write not stored");
	AST_CLEAR_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_LATCH_CLEAR) |=> latch_reset_reg == $past(i_reg_wdata[CLR_SECOND_BIT:CLR_FIRST_BIT]))
		else $error("Clear write not stored");
	AST_WINDOW_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_SECOND_WINDOW) |=> second_pulse_window == $past(i_reg_wdata))
		else $error("Window write not stored");
	AST_LATENCY_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_LATENCY_TIME) |=> latency_time == $past(i_reg_wdata))
		else $error("Latency write not stored");
	AST_CTRL_READ: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_rd && i_reg_addr == ADDR_CONTROL_ONE) |=> o_reg_rdata == $past(control_one_config))
		else $error("Control read wrong");
	AST_WINDOW_READ: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_rd && i_reg_addr == ADDR_SECOND_WINDOW) |=> o_reg_rdata == $past(second_pulse_window))
		else $error("Window read wrong");
	AST_LATENCY_READ: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_rd && i_reg_addr == ADDR_LATENCY_TIME) |=> o_reg_rdata == $past(latency_time))
		else $error("Latency read wrong");
	AST_SOURCE_AXES_READ: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_rd && i_reg_addr == ADDR_EVENT_SOURCE) |=> o_reg_rdata[SRC_LEVEL_X:SRC_PULSE_Z] == $past(axis_events))
		else $error("Source axis bits read wrong");
	AST_RDATA_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("Read data changed without a read");
	AST_SOURCE_RO_EVENTS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_reg_wr && i_reg_addr == ADDR_EVENT_SOURCE && !first_clear && !second_clear)
		|=> (axis_events & $past(axis_events)) == $past(axis_events))
		else $error("Write to source register lost an event");

	// Routing of each event type to the other flag
	AST_ASSIGN_00_SECOND: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_LEVEL_PULSE && !second_clear && single_any) |=> second_flag)
		else $error("Pulse event not latched on second flag");
	AST_ASSIGN_01_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_PULSE_LEVEL && !first_clear && single_any) |=> first_flag)
		else $error("Pulse event not latched on first flag");
	AST_ASSIGN_10_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && !first_clear && single_any) |=> first_flag)
		else $error("Single pulse not latched on first flag");
	AST_ASSIGN_10_DOUBLE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && !second_clear && double_only && i_double_pulse) |=> second_flag)
		else $error("Double pulse not latched on second flag");
	AST_ASSIGN_11_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_RESERVED && !first_clear && level_any) |=> first_flag)
		else $error("Reserved assignment lost level event");

	// Clearing, holding and keeping the flags
	AST_CLEAR_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel != ASSIGN_SINGLE_DBL && clear_first_flag) |=> !first_flag)
		else $error("First clear did not clear first flag");
	AST_CLEAR_SECOND: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		clear_second_flag |=> !second_flag)
		else $error("Second clear did not clear second flag");
	AST_KEEP_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!first_clear && first_flag) |=> first_flag)
		else $error("First flag lost without a clear");
	AST_KEEP_SECOND: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!second_clear && second_flag) |=> second_flag)
		else $error("Second flag lost without a clear");
	AST_CLEAR_HOLD_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(clear_first_flag && irq_assign_sel != ASSIGN_SINGLE_DBL) [*2] |-> !first_flag)
		else $error("First flag set while clear bit held");
	AST_SOURCE_CLEARED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(first_clear || second_clear) |=> axis_events == RST_EVENT_SOURCE[SRC_LEVEL_X:SRC_PULSE_Z])
		else $error("Axis source bits not cleared");
	AST_MODE10_SOURCE_KEPT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel == ASSIGN_SINGLE_DBL && clear_first_flag && !clear_second_flag)
		|=> (axis_events & $past(axis_events)) == $past(axis_events))
		else $error("Ignored first clear changed source bits");
	AST_RESTART_ONLY_MODE10: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(irq_assign_sel != ASSIGN_SINGLE_DBL || !clear_second_flag) |=> !o_detect_restart)
		else $error("Restart raised without a second clear");

	// Pins follow the latched flags
	AST_PIN_FIRST_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(first_flag && !irq_output_swap) |=> o_first_irq_line)
		else $error("First pin low while first flag latched");
	AST_PIN_LOW_CLEARED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!first_flag && !second_flag) |=> !o_first_irq_line && !o_second_irq_line)
		else $error("Pin high with no flag latched");
endmodule

`default_nettype wire

// ===== verification/host_reg_model.sv
// Host model driving the internal register port
`timescale 1ns/100ps
`default_nettype none
module host_reg_model (
	input  wire logic       i_clk,
	output var  logic [7:0] o_addr,
	output var  logic       o_wr,
	output var  logic [7:0] o_wdata,
	output var  logic       o_rd
);
	// Idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end
	// One-cycle strobe, then released bus drops the strobes and shows inverted address and data
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= w;
		o_rd <= ~w;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_accel_irq_routing_latch.sv
// Self-checking bench of the interrupt routing block
`timescale 1ns/100ps
`default_nettype none
module tb_accel_irq_routing_latch;
	import accel_irq_pkg::*;
	logic        sys_clk, resetn, wr, rd, dbl, irq1, irq2, restart;
	logic [7:0]  addr, wdata, rdata;
	logic [2:0]  lvl, pls;
	logic [10:0] notes[$];
	int          fail_count, checks_done;
	host_reg_model i_host_reg_model (.i_clk(sys_clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
	accel_irq_routing_latch i_accel_irq_routing_latch (.i_sys_clk(sys_clk), .i_resetn(resetn),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
		.i_level_event_x(lvl[2]), .i_level_event_y(lvl[1]), .i_level_event_z(lvl[0]),
		.i_first_pulse_x(pls[2]), .i_first_pulse_y(pls[1]), .i_first_pulse_z(pls[0]), .i_double_pulse(dbl),
		.o_reg_rdata(rdata), .o_first_irq_line(irq1), .o_second_irq_line(irq2), .o_detect_restart(restart));
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (notes.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		i_host_reg_model.access(a, d, 1'b1);
		repeat (2) @(posedge sys_clk);
	endtask
	// Read, noting {restart, pin2, pin1, data}; crossed pins swap the flags
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] d, input logic [1:0] f, input logic sw,
		input logic rs);
		notes.push_back({rs, (sw ? {f[0], f[1]} : f), d});
		i_host_reg_model.access(a, 8'h00, 1'b0);
	endtask
	// One-cycle detector events, then settle
	task automatic fire(input logic [2:0] l, input logic [2:0] p, input logic d);
		@(posedge sys_clk);
		lvl <= l;
		pls <= p;
		dbl <= d;
		@(posedge sys_clk);
		lvl <= 3'h0;
		pls <= 3'h0;
		dbl <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	// Compare each read answer with the oldest note
	always @(posedge sys_clk) begin
		if (rd) begin
			#1;
			chk("read", {restart, irq2, irq1, rdata}, notes.pop_front());
		end
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		logic [1:0] asg;
		logic [2:0] ax;
		logic       sw;
		resetn = 1'b0;
		lvl = 3'h0;
		pls = 3'h0;
		dbl = 1'b0;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(32'hb51b));
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		rd_exp(ADDR_LATCH_CLEAR, 8'h00, 2'b00, 1'b0, 1'b0);
		rd_exp(ADDR_CONTROL_ONE, 8'h00, 2'b00, 1'b0, 1'b0);
		rd_exp(ADDR_SECOND_WINDOW, 8'h00, 2'b00, 1'b0, 1'b0);
		rd_exp(8'h33, 8'h00, 2'b00, 1'b0, 1'b0);
		wreg(ADDR_EVENT_SOURCE, 8'hff);
		rd_exp(ADDR_EVENT_SOURCE, 8'h00, 2'b00, 1'b0, 1'b0);
		$display("test reset_values done");
		for (int k = 0; k < 6; k++) begin
			asg = (k > 3) ? 2'b11 : 2'(k / 2);
			sw = k[0];
			ax = 3'h1 << ($urandom % 3);
			wreg(ADDR_CONTROL_ONE, {5'h00, asg, sw});
			fire(ax, 3'h0, 1'b0);
			rd_exp(ADDR_EVENT_SOURCE, {ax, 5'h00} | ((asg == 2'b01) ? 8'h02 : 8'h01),
				(asg == 2'b01) ? 2'b10 : 2'b01, sw, 1'b0);
			fire(3'h0, ax, 1'b0);
			rd_exp(ADDR_EVENT_SOURCE, {ax, ax, 2'b11}, 2'b11, sw, 1'b0);
			wreg(ADDR_LATCH_CLEAR, 8'h01);
			fire(ax, ax, 1'b0);
			rd_exp(ADDR_EVENT_SOURCE, 8'h02, 2'b10, sw, 1'b0);
			rd_exp(ADDR_LATCH_CLEAR, 8'h01, 2'b10, sw, 1'b0);
			wreg(ADDR_LATCH_CLEAR, 8'h02);
			wreg(ADDR_LATCH_CLEAR, 8'h00);
			rd_exp(ADDR_EVENT_SOURCE, 8'h00, 2'b00, sw, 1'b0);
		end
		$display("test assign_route_clear done");
		wreg(ADDR_CONTROL_ONE, 8'h05);
		fire(3'h0, 3'h4, 1'b0);
		rd_exp(ADDR_EVENT_SOURCE, 8'h13, 2'b11, 1'b1, 1'b0);
		wreg(ADDR_LATCH_CLEAR, 8'h01);
		wreg(ADDR_LATCH_CLEAR, 8'h00);
		rd_exp(ADDR_EVENT_SOURCE, 8'h13, 2'b11, 1'b1, 1'b0);
		wreg(ADDR_LATCH_CLEAR, 8'h02);
		rd_exp(ADDR_EVENT_SOURCE, 8'h00, 2'b00, 1'b1, 1'b1);
		wreg(ADDR_LATCH_CLEAR, 8'h00);
		wreg(ADDR_SECOND_WINDOW, 8'h05);
		rd_exp(ADDR_SECOND_WINDOW, 8'h05, 2'b00, 1'b1, 1'b0);
		fire(3'h0, 3'h1, 1'b0);
		rd_exp(ADDR_EVENT_SOURCE, 8'h05, 2'b01, 1'b1, 1'b0);
		fire(3'h0, 3'h0, 1'b1);
		rd_exp(ADDR_EVENT_SOURCE, 8'h07, 2'b11, 1'b1, 1'b0);
		wreg(ADDR_LATCH_CLEAR, 8'h02);
		wreg(ADDR_LATCH_CLEAR, 8'h00);
		rd_exp(ADDR_LATENCY_TIME, 8'h01, 2'b00, 1'b1, 1'b0);
		wreg(ADDR_LATENCY_TIME, 8'h00);
		fire(3'h4, 3'h1, 1'b0);
		rd_exp(ADDR_EVENT_SOURCE, 8'h87, 2'b11, 1'b1, 1'b0);
		$display("test single_double done");
		repeat (4) @(posedge sys_clk);
		wrap_up();
	end
endmodule
`default_nettype wire
